// ### design/dpf_plane_fetch.sv
// Plane fetch: page walker, rotation ordering, control surface lookup.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "dpf_params.svh"
module dpf_plane_fetch (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Memory read request and return
  output logic             mem_req_valid,
  output logic      [31:0] mem_req_addr,
  output logic             mem_req_ccs,
  input  wire logic        mem_req_ready,
  input  wire logic        mem_rd_valid,
  input  wire logic [31:0] mem_rd_data,
  // Pixel data out
  output logic             pix_valid,
  output logic      [31:0] pix_data,
  output logic      [1:0]  pix_state,
  output logic             pix_compressed,
  output logic             frame_done
);
  logic [31:0] ctrl, base, next_ctrl, next_base, aux, next_aux;
  logic [9:0]  stride, hgt, shgt, next_stride, next_hgt, next_shgt;
  logic [7:0]  dph_addr, next_dph_addr;
  logic        dph_wr, next_dph_wr, start, next_start;
  logic [31:0] next_hrdata;
  dpf_pkg::dpf_state_t st, next_st;
  logic [19:0] pg, next_pg, npages;
  logic [9:0]  px, py, next_px, next_py, px_e, py_e, rows;
  logic [5:0]  ln, next_ln, ln_e;
  logic [31:0] ccs_word, next_ccs_word;
  logic        next_req_valid, next_req_ccs, next_pix_valid;
  logic        next_pix_cmp, next_done;
  logic [31:0] next_req_addr, next_pix_data, line_addr, ccs_addr;
  logic [1:0]  next_pix_state, rot;
  logic        decomp_act, rot_swap;
  logic [3:0]  pair_idx;

  function automatic logic [31:0] ytile(input logic [31:0] xb,
                                        input logic [9:0]  y,
                                        input logic [9:0]  str);
    logic [31:0] t;
    t = 32'({5'h0, y[9:5]}) * 32'(str) + (xb >> 7);
    ytile = (t << `DPF_PG_SH) | {20'h0, xb[6:4], y[4:0], xb[3:0]};
  endfunction : ytile

  // Bus: address phase captured, answered in the next cycle, no waits.
  always_comb
  begin
    next_dph_addr = dph_addr;
    next_dph_wr   = 1'b0;
    next_hrdata   = hrdata;
    if (hsel && hready && htrans[1])
    begin
      next_dph_addr = haddr[7:0];
      next_dph_wr   = hwrite;
      unique case (haddr[7:0])
        `DPF_A_CTRL:   next_hrdata = ctrl;
        `DPF_A_BASE:   next_hrdata = base;
        `DPF_A_STRIDE: next_hrdata = {22'h0, stride};
        `DPF_A_HGT:    next_hrdata = {22'h0, hgt};
        `DPF_A_AUX:    next_hrdata = aux;
        `DPF_A_SHGT:   next_hrdata = {22'h0, shgt};
        `DPF_A_STAT:   next_hrdata = {28'h0, decomp_act,
                                      st != dpf_pkg::DPF_IDLE, rot};
        default:       next_hrdata = 32'h0;
      endcase
    end
  end

  always_comb
  begin
    next_ctrl   = ctrl;
    next_base   = base;
    next_stride = stride;
    next_hgt    = hgt;
    next_aux    = aux;
    next_shgt   = shgt;
    next_start  = 1'b0;
    if (dph_wr)
    begin
      unique case (dph_addr)
        `DPF_A_CTRL:   next_ctrl = {24'h0, hwdata[7:0]};
        `DPF_A_BASE:   next_base = hwdata;
        `DPF_A_STRIDE: next_stride = hwdata[9:0];
        `DPF_A_HGT:    next_hgt = hwdata[9:0];
        `DPF_A_AUX:    next_aux = {hwdata[`DPF_AUX_DIST], 2'h0,
                                   hwdata[`DPF_AUX_STR]};
        `DPF_A_SHGT:   next_shgt = hwdata[9:0];
        `DPF_A_START:  next_start = hwdata[0];
        default:       next_start = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl <= 32'h0; base <= 32'h0; stride <= 10'h0; hgt <= 10'h0;
      aux <= 32'h0; shgt <= 10'h0; start <= 1'b0;
      dph_addr <= 8'h0; dph_wr <= 1'b0; hrdata <= 32'h0;
      hreadyout <= 1'b0; hresp <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl; base <= next_base; stride <= next_stride;
      hgt <= next_hgt; aux <= next_aux; shgt <= next_shgt;
      start <= next_start; dph_addr <= next_dph_addr;
      dph_wr <= next_dph_wr; hrdata <= next_hrdata;
      hreadyout <= 1'b1; hresp <= 1'b0;
    end
  end

  // Decompression is gated per plane; each plane carries this block.
  assign rot      = ctrl[`DPF_C_ROT];
  assign rot_swap = rot == `DPF_ROT_90 || rot == `DPF_ROT_270;
  assign decomp_act = ctrl[`DPF_C_DECOMP]
    && (ctrl[`DPF_C_TILE] == `DPF_TILE_Y
        || ctrl[`DPF_C_TILE] == `DPF_TILE_YF)
    && (ctrl[`DPF_C_FMT] == `DPF_FMT_8888
        || ctrl[`DPF_C_FMT] == `DPF_FMT_1010)
    && !rot_swap;

  // Remapped translations hide the rotated page walk; shgt gives rows for 90/270, hgt otherwise.
  assign rows   = rot_swap ? shgt : hgt;
  // Widen before the product so large planes do not wrap the page count.
  assign npages = 20'(stride) * 20'(rows);
  assign px_e   = (rot == `DPF_ROT_180) ? stride - px - 10'h1 : px;
  assign py_e   = (rot == `DPF_ROT_180) ? rows - py - 10'h1 : py;

  always_comb
  begin
    unique case (rot)
      `DPF_ROT_180: ln_e = ~ln;
      `DPF_ROT_90:  ln_e = {ln[2:0], ln[5:3]};
      `DPF_ROT_270: ln_e = ~{ln[2:0], ln[5:3]};
      default:      ln_e = ln;
    endcase
  end

  assign line_addr = base
    + ({12'h0, (rot == `DPF_ROT_180) ? npages - 20'h1 - pg : pg}
       << `DPF_PG_SH)
    + {20'h0, ln_e, 6'h0};
  // One control word holds 16 pair states, a line holds 16 words.
  assign ccs_addr = base + {aux[`DPF_AUX_DIST], 12'h0}
    + ytile({19'h0, px_e[9:3], px_e[2:0], ln_e[5], 2'h0}, py_e,
            aux[`DPF_AUX_STR]);
  assign pair_idx = ln_e[4:1];

  always_comb
  begin
    next_st        = st;
    next_pg        = pg;
    next_px        = px;
    next_py        = py;
    next_ln        = ln;
    next_ccs_word  = ccs_word;
    next_req_valid = mem_req_valid;
    next_req_addr  = mem_req_addr;
    next_req_ccs   = mem_req_ccs;
    next_pix_valid = 1'b0;
    next_pix_data  = pix_data;
    next_pix_state = pix_state;
    next_pix_cmp   = pix_compressed;
    next_done      = 1'b0;
    unique case (st)
      dpf_pkg::DPF_IDLE:
        if (start && npages != 20'h0)
        begin
          next_pg = 20'h0; next_px = 10'h0; next_py = 10'h0;
          next_ln = 6'h0;
          next_st = decomp_act ? dpf_pkg::DPF_CCS_REQ
                               : dpf_pkg::DPF_LN_REQ;
        end
      dpf_pkg::DPF_CCS_REQ:
      begin
        next_req_valid = 1'b1;
        next_req_addr  = ccs_addr;
        next_req_ccs   = 1'b1;
        next_st        = dpf_pkg::DPF_CCS_WAIT;
      end
      dpf_pkg::DPF_CCS_WAIT:
      begin
        if (mem_req_valid && mem_req_ready)
          next_req_valid = 1'b0;
        if (mem_rd_valid)
        begin
          next_ccs_word = mem_rd_data;
          next_st       = dpf_pkg::DPF_LN_REQ;
        end
      end
      dpf_pkg::DPF_LN_REQ:
      begin
        next_req_valid = 1'b1;
        next_req_addr  = line_addr;
        next_req_ccs   = 1'b0;
        next_st        = dpf_pkg::DPF_LN_WAIT;
      end
      dpf_pkg::DPF_LN_WAIT:
      begin
        if (mem_req_valid && mem_req_ready)
          next_req_valid = 1'b0;
        if (mem_rd_valid)
        begin
          next_pix_valid = 1'b1;
          next_pix_data  = mem_rd_data;
          next_pix_state = decomp_act
            ? ccs_word[{pair_idx, 1'b0} +: 2] : `DPF_ST_UNCMP;
          next_pix_cmp   = decomp_act
            && ccs_word[{pair_idx, 1'b0} +: 2] != `DPF_ST_UNCMP;
          next_ln = ln + 6'h1;
          next_st = (decomp_act && ln + 6'h1 == `DPF_LN_HALF)
                    ? dpf_pkg::DPF_CCS_REQ : dpf_pkg::DPF_LN_REQ;
          if (ln == `DPF_LN_LAST)
          begin
            next_pg = pg + 20'h1;
            next_px = (px == stride - 10'h1) ? 10'h0 : px + 10'h1;
            next_py = (px == stride - 10'h1) ? py + 10'h1 : py;
            if (pg == npages - 20'h1)
            begin
              next_st   = dpf_pkg::DPF_IDLE;
              next_done = 1'b1;
            end
            else
              next_st = decomp_act ? dpf_pkg::DPF_CCS_REQ
                                   : dpf_pkg::DPF_LN_REQ;
          end
        end
      end
      default: next_st = dpf_pkg::DPF_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= dpf_pkg::DPF_IDLE; pg <= 20'h0; px <= 10'h0; py <= 10'h0;
      ln <= 6'h0; ccs_word <= 32'h0; mem_req_valid <= 1'b0;
      mem_req_addr <= 32'h0; mem_req_ccs <= 1'b0; pix_valid <= 1'b0;
      pix_data <= 32'h0; pix_state <= 2'h0; pix_compressed <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      st <= next_st; pg <= next_pg; px <= next_px; py <= next_py;
      ln <= next_ln; ccs_word <= next_ccs_word;
      mem_req_valid <= next_req_valid; mem_req_addr <= next_req_addr;
      mem_req_ccs <= next_req_ccs; pix_valid <= next_pix_valid;
      pix_data <= next_pix_data; pix_state <= next_pix_state;
      pix_compressed <= next_pix_cmp; frame_done <= next_done;
    end
  end

  // Checks on the walker and the decompression gate.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_ccs_issue;
    st == dpf_pkg::DPF_CCS_REQ ##1 mem_req_ccs;
  endsequence

  AST_ROT_NO_DECOMP: assert property (
    rot_swap |-> !(mem_req_valid && mem_req_ccs)
      && !(pix_valid && pix_compressed))
    else $error("decomp with 90/270");
  AST_TILE_GATE: assert property (
    mem_req_valid && mem_req_ccs |-> ctrl[`DPF_C_TILE] == `DPF_TILE_Y
      || ctrl[`DPF_C_TILE] == `DPF_TILE_YF)
    else $error("decomp on non-Y tiling");
  AST_ENABLE_GATE: assert property (
    (mem_req_valid && mem_req_ccs) || (pix_valid && pix_compressed)
      |-> ctrl[`DPF_C_DECOMP])
    else $error("control fetch while disabled");
  AST_FMT_GATE: assert property (
    pix_valid && pix_compressed |-> ctrl[`DPF_C_FMT] == `DPF_FMT_8888
      || ctrl[`DPF_C_FMT] == `DPF_FMT_1010)
    else $error("decomp on bad format");
  AST_PASS: assert property (
    st == dpf_pkg::DPF_LN_WAIT && mem_rd_valid |=>
      pix_valid && pix_data == $past(mem_rd_data)
      && (pix_state != `DPF_ST_UNCMP || !pix_compressed))
    else $error("data not passed through");
  AST_180_FIRST: assert property (
    st == dpf_pkg::DPF_LN_REQ && rot == `DPF_ROT_180 && pg == 20'h0
      && ln == 6'h0 |=> mem_req_addr == base
        + ({12'h0, npages - 20'h1} << `DPF_PG_SH) + 32'hfc0)
    else $error("180 walk not reversed");
  AST_CCS_ADDR: assert property (
    st == dpf_pkg::DPF_CCS_REQ && px == 10'h0 && py == 10'h0
      && ln == 6'h0 && rot == `DPF_ROT_0 |=>
      mem_req_ccs && mem_req_addr == base + {aux[`DPF_AUX_DIST], 12'h0})
    else $error("control surface address wrong");
  AST_90_ORDER: assert property (
    st == dpf_pkg::DPF_LN_REQ && rot == `DPF_ROT_90 && ln == 6'h1
      |=> mem_req_addr == base + ({12'h0, pg} << `DPF_PG_SH) + 32'h200)
    else $error("90 in-page order wrong");
  AST_CCS_FIRST: assert property (
    st == dpf_pkg::DPF_IDLE && start && npages != 20'h0 && decomp_act
      |=> s_ccs_issue)
    else $error("no control fetch at frame start");
endmodule : dpf_plane_fetch

// ### design/dpf_params.svh
// Constants for the plane fetch block: addresses, fields, encodings.
`ifndef DPF_PARAMS_SVH
`define DPF_PARAMS_SVH
`define DPF_A_CTRL   8'h00
`define DPF_A_BASE   8'h04
`define DPF_A_STRIDE 8'h08
`define DPF_A_HGT    8'h0c
`define DPF_A_AUX    8'h10
`define DPF_A_SHGT   8'h14
`define DPF_A_STAT   8'h18
`define DPF_A_START  8'h1c
`define DPF_C_DECOMP 1
`define DPF_C_ROT    3:2
`define DPF_C_TILE   5:4
`define DPF_C_FMT    7:6
`define DPF_AUX_DIST 31:12
`define DPF_AUX_STR  9:0
`define DPF_ROT_0    2'h0
`define DPF_ROT_90   2'h1
`define DPF_ROT_180  2'h2
`define DPF_ROT_270  2'h3
`define DPF_TILE_Y   2'h2
`define DPF_TILE_YF  2'h3
`define DPF_FMT_8888 2'h0
`define DPF_FMT_1010 2'h1
`define DPF_ST_UNCMP 2'h0
`define DPF_LN_LAST  6'h3f
`define DPF_LN_HALF  6'h20
`define DPF_PG_SH    12
`define DPF_LN_SH    6
`endif

// ### design/dpf_pkg.sv
// Types shared by the plane fetch block.
package dpf_pkg;
  typedef enum logic [2:0] {
    DPF_IDLE     = 3'h0,
    DPF_CCS_REQ  = 3'h1,
    DPF_CCS_WAIT = 3'h3,
    DPF_LN_REQ   = 3'h2,
    DPF_LN_WAIT  = 3'h6
  } dpf_state_t;
endpackage : dpf_pkg

// ### verification/dpf_mem_model.sv
// Behavioural graphics memory behind an identity page translation.
`timescale 1ns/1ps
module dpf_mem_model #(
  parameter logic [31:0] CCS_WORD = 32'h1b39_c6e4
) (
  // Clock, reset and pacing
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        slow,
  // Request and return
  input  wire logic        mem_req_valid,
  input  wire logic [31:0] mem_req_addr,
  input  wire logic        mem_req_ccs,
  output logic             mem_req_ready,
  output logic             mem_rd_valid,
  output logic      [31:0] mem_rd_data
);
  logic [2:0]  cnt;
  logic        pend;
  logic [31:0] held;
  // Translation is the identity, so a rotated walk reads plain pages.
  // Both surfaces are held in the clear alike, never one alone.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {mem_req_ready, mem_rd_valid, pend, cnt, held} <= '0;
      mem_rd_data <= 32'h0;
    end
    else
    begin
      mem_req_ready <= 1'b0;
      mem_rd_valid  <= 1'b0;
      // Idle data toggles so a stale word is never taken for a return.
      mem_rd_data   <= ~mem_rd_data;
      if ((mem_req_valid && !mem_req_ready) || pend)
      begin
        if (cnt != (slow ? 3'h3 : 3'h0))
          cnt <= cnt + 3'h1;
        else if (!pend)
        begin
          mem_req_ready <= 1'b1;
          pend          <= 1'b1;
          held <= mem_req_ccs ? CCS_WORD : mem_req_addr ^ 32'ha5c3_0f96;
          cnt           <= 3'h0;
        end
        else
        begin
          mem_rd_valid <= 1'b1;
          mem_rd_data  <= held;
          pend         <= 1'b0;
          cnt          <= 3'h0;
        end
      end
    end
  end
endmodule : dpf_mem_model

// ### verification/testbench.sv
// Self-checking bench for the plane fetch block.
`timescale 1ns/1ps
`include "dpf_params.svh"
module testbench;
  localparam logic [31:0] BASE = 32'h0010_0000;
  localparam logic [31:0] CCSW = 32'h1b39_c6e4;
  logic        mclk    = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        slow    = 1'b0;
  logic [31:0] hrdata, mem_req_addr, mem_rd_data, pix_data;
  logic        hreadyout, hresp, mem_req_valid, mem_req_ccs, mem_req_ready;
  logic        mem_rd_valid, pix_valid, pix_compressed, frame_done;
  logic [1:0]  pix_state;
  int          err_count = 0;
  int          compares  = 0;
  logic [32:0] rq[$];
  logic [34:0] pq[$];

  always #12.5 mclk = ~mclk;

  dpf_plane_fetch dpf_plane_fetch_i (
    .mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req_valid,
    .mem_req_addr, .mem_req_ccs, .mem_req_ready, .mem_rd_valid,
    .mem_rd_data, .pix_valid, .pix_data, .pix_state, .pix_compressed,
    .frame_done);
  dpf_mem_model #(.CCS_WORD(CCSW)) dpf_mem_model_i (
    .mclk, .reset_n, .slow, .mem_req_valid, .mem_req_addr, .mem_req_ccs,
    .mem_req_ready, .mem_rd_valid, .mem_rd_data);

  // Accepted requests and delivered lines, in arrival order.
  always @(posedge mclk)
  begin
    if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1)
      rq.push_back({mem_req_ccs, mem_req_addr});
    if (pix_valid === 1'b1)
      pq.push_back({pix_compressed, pix_state, pix_data});
  end

  task automatic close_out();
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [34:0] e,
                     input logic [34:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Entered just after a rising edge; returns just after one.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, {3'h0, e}, {3'h0, r});
    chk("resp", 35'h0, {34'h0, hresp});
  endtask : rc

  function automatic logic [31:0] cw(logic d, logic [1:0] rt,
                                     logic [1:0] tl, logic [1:0] fm);
    return {24'h0, fm, tl, rt, d, 1'b0};
  endfunction : cw

  task automatic regs();
    rc("ctrl", `DPF_A_CTRL, 32'h0);
    rc("status", `DPF_A_STAT, 32'h0);
    wr(`DPF_A_BASE, BASE);
    wr(`DPF_A_AUX, 32'h0000_3004);
    rc("base", `DPF_A_BASE, BASE);
    rc("aux", `DPF_A_AUX, 32'h0000_3004);
    rc("unmapped", 8'h20, 32'h0);
    wr(`DPF_A_CTRL, cw(1'b0, `DPF_ROT_180, 2'h0, 2'h0));
    rc("status rot", `DPF_A_STAT, 32'h2);
    wr(`DPF_A_CTRL, cw(1'b1, `DPF_ROT_0, `DPF_TILE_Y, `DPF_FMT_8888));
    rc("ctrl back", `DPF_A_CTRL, 32'h22);
    rc("status dec", `DPF_A_STAT, 32'h8);
    wr(`DPF_A_CTRL, cw(1'b1, `DPF_ROT_90, `DPF_TILE_Y, `DPF_FMT_8888));
    rc("status 90", `DPF_A_STAT, 32'h1);
    rc("start", `DPF_A_START, 32'h0);
  endtask : regs

  // One frame of np pages in a single row; dec says if control words come.
  task automatic frame(input logic [31:0] ctrl, input logic [9:0] np,
                       input logic [9:0] hgt, input logic sl,
                       input logic dec);
    logic [5:0]  ln;
    logic [31:0] a;
    logic [1:0]  st;
    int          n, pg;
    n = 0;
    slow <= sl;
    wr(`DPF_A_CTRL, ctrl);
    wr(`DPF_A_STRIDE, {22'h0, np});
    wr(`DPF_A_HGT, {22'h0, hgt});
    wr(`DPF_A_SHGT, 32'h1);
    rq.delete();
    pq.delete();
    wr(`DPF_A_START, 32'h1);
    // The walker leaves idle one edge after the start lands.
    @(posedge mclk);
    rc("busy", `DPF_A_STAT,
       {28'h0, dec, 1'b1, ctrl[`DPF_C_ROT]});
    while (frame_done !== 1'b1 && n++ < 20000)
      @(posedge mclk);
    chk("frame done", 35'h1, {34'h0, frame_done});
    repeat (2) @(posedge mclk);
    chk("requests", 35'(np * (dec ? 66 : 64)), 35'(rq.size()));
    chk("lines", 35'(np * 64), 35'(pq.size()));
    if (35'(rq.size()) !== 35'(np * (dec ? 66 : 64)) ||
        35'(pq.size()) !== 35'(np * 64))
      return;
    for (int p = 0; p < np; p++)
      for (int l = 0; l < 64; l++)
      begin
        pg = (ctrl[`DPF_C_ROT] == `DPF_ROT_180) ? np - 1 - p : p;
        ln = 6'(l);
        case (ctrl[`DPF_C_ROT])
          `DPF_ROT_180: ln = 6'h3f - ln;
          `DPF_ROT_90:  ln = {ln[2:0], ln[5:3]};
          `DPF_ROT_270: ln = ~{ln[2:0], ln[5:3]};
          default:      ln = ln;
        endcase
        a = BASE + 32'h3000 + 32'(p * 8) + (ln[5] ? 32'h4 : 32'h0);
        if (dec && ln[4:0] == 5'h0)
          chk("ctrl word", {2'h0, 1'b1, a}, rq.pop_front());
        a = BASE + 32'(pg * 4096) + {20'h0, ln, 6'h0};
        chk("line", {2'h0, 1'b0, a},
            rq.pop_front());
        st = dec ? CCSW[{ln[4:1], 1'b0} +: 2] : 2'h0;
        chk("pixel", {st != 2'h0, st, a ^ 32'ha5c3_0f96},
            pq.pop_front());
      end
  endtask : frame

  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    regs();
    frame(cw(0, `DPF_ROT_0, `DPF_TILE_Y, `DPF_FMT_8888), 1, 1, 1, 0);
    frame(cw(1, `DPF_ROT_0, `DPF_TILE_Y, `DPF_FMT_8888), 2, 1, 0,
          1);
    frame(cw(1, `DPF_ROT_0, `DPF_TILE_YF, `DPF_FMT_1010), 1, 1, 1, 1);
    frame(cw(1, `DPF_ROT_0, 2'h0, `DPF_FMT_8888), 1, 1, 0, 0);
    frame(cw(1, `DPF_ROT_0, `DPF_TILE_Y, 2'h2), 1, 1, 0, 0);
    frame(cw(0, `DPF_ROT_180, `DPF_TILE_Y, 2'h0), 2, 1, 1, 0);
    frame(cw(1, `DPF_ROT_90, `DPF_TILE_Y, 2'h0), 1, 0, 0,
          0);
    frame(cw(1, `DPF_ROT_270, `DPF_TILE_Y, 2'h0), 1, 0, 1, 0);
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    err_count++;
    close_out();
  end
endmodule : testbench
